// *** src/sspsq_pkg.sv ***
package sspsq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ        = 200;
  localparam int          PBO_HOLD_MS    = 4000;
  localparam int unsigned PBO_CYCLES     = PBO_HOLD_MS * CLK_MHZ * 1000;
  localparam int          PBO_W          = 30;
  localparam int          DLY_W          = 16;
  localparam int          PG_RISE_NS     = 1000;
  localparam int          PG_RISE_CYCLES = (PG_RISE_NS * CLK_MHZ + 999) / 1000;
  localparam int          NB_PG_NS       = 500;
  localparam int          NB_PG_CYCLES   = (NB_PG_NS * CLK_MHZ + 999) / 1000;
  localparam int          PG_CNT_W       = 12;

  // ----------------------------------------------------------------
  // Sleep types and pin levels
  // ----------------------------------------------------------------
  localparam logic [2:0] SLP_S1 = 3'h1;
  localparam logic [2:0] S3_PLANE_OFF_N = 3'h3;
  localparam logic [2:0] SLP_S4 = 3'h4;
  localparam logic [2:0] S5_PLANE_OFF_N = 3'h5;

  localparam logic PIN_ASSERT_N  = 1'b0;
  localparam logic PIN_RELEASE_N = 1'b1;
  localparam logic OE_DRIVE_N    = 1'b0;
  localparam logic OE_FLOAT_N    = 1'b1;
  localparam logic OD_LOW        = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN      = 4'h0,
    ST_WAIT_GNT = 4'h1,
    ST_SUSP     = 4'h3,
    ST_LSTOP    = 4'h2,
    ST_SLEEP    = 4'h6,
    ST_WAKE_PG  = 4'h7,
    ST_WAKE_DLY = 4'h5,
    ST_WAKE_LS  = 4'h4,
    ST_WAKE_SUS = 4'hc,
    ST_C3_GNT   = 4'h8,
    ST_C3_LS    = 4'h9,
    ST_C3       = 4'hb,
    ST_C3_EXIT  = 4'ha
  } sspsq_state_e;

  typedef enum logic [1:0] {
    ALR_SMI_GPE    = 2'h0,
    ALR_SCI        = 2'h1,
    ALR_IRQ13      = 2'h2,
    ALR_SMI_DIRECT = 2'h3
  } sspsq_alert_e;

endpackage

// *** src/sspsq_if.sv ***
interface sspsq_if;
  // Inputs to the sequencer from board, processor and northbridge
  logic power_button_n;
  logic device_power_good;
  logic northbridge_power_good;
  logic force_off_n;
  logic thermal_trip_n;
  logic thermal_alert_n;
  logic pcie_wake_n;
  logic idle_break_n;
  logic stop_grant_message;
  // Push-pull outputs of the sequencer
  logic cpu_clock_stop_n;
  logic s3_plane_off_n;
  logic s5_plane_off_n;
  // Open-drain drivers, enable low pulls the line low
  logic suspend_status_o;
  logic suspend_status_oe_n;
  logic dev_link_stop_o;
  logic dev_link_stop_oe_n;
  logic nb_link_stop_o;
  logic nb_link_stop_oe_n;
  logic dev_permit_o;
  logic dev_permit_oe_n;
  logic nb_permit_o;
  logic nb_permit_oe_n;
  // Resolved wired-AND lines with pull-ups
  logic cpu_link_stop_n;
  logic stop_permit_in;
  logic suspend_status_n;

  assign cpu_link_stop_n  = (dev_link_stop_oe_n | dev_link_stop_o) &
                            (nb_link_stop_oe_n | nb_link_stop_o);
  assign stop_permit_in   = (dev_permit_oe_n | dev_permit_o) & (nb_permit_oe_n | nb_permit_o);
  assign suspend_status_n = suspend_status_oe_n | suspend_status_o;

  modport dev (
    input  power_button_n, device_power_good, northbridge_power_good, force_off_n,
    input  thermal_trip_n, thermal_alert_n, pcie_wake_n, idle_break_n, stop_grant_message,
    input  cpu_link_stop_n, stop_permit_in, suspend_status_n,
    output cpu_clock_stop_n, s3_plane_off_n, s5_plane_off_n,
    output suspend_status_o, suspend_status_oe_n, dev_link_stop_o, dev_link_stop_oe_n,
    output dev_permit_o, dev_permit_oe_n
  );

  modport far (
    output power_button_n, device_power_good, northbridge_power_good, force_off_n,
    output thermal_trip_n, thermal_alert_n, pcie_wake_n, idle_break_n, stop_grant_message,
    output nb_link_stop_o, nb_link_stop_oe_n, nb_permit_o, nb_permit_oe_n,
    input  cpu_link_stop_n, stop_permit_in, suspend_status_n,
    input  cpu_clock_stop_n, s3_plane_off_n, s5_plane_off_n
  );
endinterface

// *** src/sspsq_device.sv ***
// What this block does
// - Link stop held off while permit low
// - Combined mode: drive permit pin toward northbridge
// - Link stop after suspend status, or stop grant
// - Programmed delays before link stop release
// - S3-S5 wake: link stop waits power good
// - Link stop line is shared wired-AND
// - Idle break input ends C3
// - Button: sleep request running, wake asleep
// - Four second hold forces S5, button-only wake
// - Board power good follows planes, northbridge
// - Forced shutdown asserts both planes at once
// - Thermal trip enters S5 at once
// - S3 plane after clock stop, freed on wake
// - S5 plane only for S4/S5
// - Suspend status after grant, freed after link stop
// - Thermal alert routed to SMI, SCI or IRQ13
// - Wake pin starts legacy, native by software
// - Wake pin low raises wake event S0-S5
// - S5 wake armed after one S5-S0-S5 cycle
module sspsq_device
  import sspsq_pkg::*;
#(
  parameter int unsigned PBO_HOLD_CYCLES = PBO_CYCLES,
  parameter int          DW              = DLY_W
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Link toward board, processor and northbridge
  sspsq_if.dev               lnk,
  // Software-side controls
  input  wire logic          i_sleep_req,
  input  wire logic [2:0]    i_sleep_type,
  input  wire logic          i_c3_req,
  input  wire logic          i_combined_link_mode,
  input  wire logic          i_dma_busy,
  input  wire logic [DW-1:0] i_s1_exit_cycles,
  input  wire logic [DW-1:0] i_c3_exit_cycles,
  input  wire logic          i_pb_use_sci,
  input  wire logic [1:0]    i_alert_route,
  input  wire logic          i_native_wake_wr,
  input  wire logic          i_native_wake_data,
  // Events and status
  output logic               o_smi,
  output logic               o_sci,
  output logic               o_irq13,
  output logic               o_wake_event,
  output logic               o_native_wake,
  output logic               o_pbo_lock,
  output logic               o_s5_wake_armed,
  output sspsq_state_e       o_state
);

  // ----------------------------------------------------------------
  // Input history and edges
  // ----------------------------------------------------------------
  logic pb_prev_reg;
  logic off_prev_reg;
  logic trip_prev_reg;
  logic alert_prev_reg;
  logic wake_prev_reg;

  // History resets to the idle-high level so no edge fires at release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pb_prev_reg    <= PIN_RELEASE_N;
      off_prev_reg   <= PIN_RELEASE_N;
      trip_prev_reg  <= PIN_RELEASE_N;
      alert_prev_reg <= PIN_RELEASE_N;
      wake_prev_reg  <= PIN_RELEASE_N;
    end else begin
      pb_prev_reg    <= lnk.power_button_n;
      off_prev_reg   <= lnk.force_off_n;
      trip_prev_reg  <= lnk.thermal_trip_n;
      alert_prev_reg <= lnk.thermal_alert_n;
      wake_prev_reg  <= lnk.pcie_wake_n;
    end
  end

  logic pb_fall;
  logic off_fall;
  logic trip_fall;
  logic alert_fall;
  logic wake_fall;
  assign pb_fall    = pb_prev_reg & ~lnk.power_button_n;
  assign off_fall   = off_prev_reg & ~lnk.force_off_n;
  assign trip_fall  = trip_prev_reg & ~lnk.thermal_trip_n;
  assign alert_fall = alert_prev_reg & ~lnk.thermal_alert_n;
  assign wake_fall  = wake_prev_reg & ~lnk.pcie_wake_n;

  // ----------------------------------------------------------------
  // Power button override
  // ----------------------------------------------------------------
  logic [PBO_W-1:0] pbo_cnt_reg;
  logic             pbo_fire;
  assign pbo_fire = ~lnk.power_button_n & (pbo_cnt_reg == PBO_W'(PBO_HOLD_CYCLES - 1));

  // Saturates at the limit so one long hold fires exactly once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pbo_cnt_reg <= '0;
    end else if (lnk.power_button_n) begin
      pbo_cnt_reg <= '0;
    end else if (pbo_cnt_reg != PBO_W'(PBO_HOLD_CYCLES)) begin
      pbo_cnt_reg <= pbo_cnt_reg + PBO_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sspsq_state_e  state_reg;
  logic [2:0]    type_reg;
  logic [DW-1:0] dly_reg;
  logic          link_req_reg;
  logic          susp_oe_n_reg;
  logic          clk_stop_n_reg;
  logic          s3_off_n_reg;
  logic          s5_off_n_reg;
  logic          pbo_lock_reg;
  logic          s5_armed_reg;
  logic          native_reg;

  logic force_s5;
  logic in_s5;
  logic wake_src_ok;
  logic sleep_wake;
  logic type_ok;
  assign in_s5       = (state_reg == ST_SLEEP) && (type_reg == S5_PLANE_OFF_N);
  assign force_s5    = (off_fall | trip_fall | pbo_fire) & ~in_s5;
  assign wake_src_ok = ~pbo_lock_reg & ((type_reg != S5_PLANE_OFF_N) | s5_armed_reg);
  assign sleep_wake  = pb_fall | (~lnk.pcie_wake_n & wake_src_ok);
  assign type_ok     = (i_sleep_type >= SLP_S1) && (i_sleep_type <= S5_PLANE_OFF_N);

  // Power-up comes out of G3 into S5 with every control asserted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg      <= ST_SLEEP;
      type_reg       <= S5_PLANE_OFF_N;
      dly_reg        <= '0;
      link_req_reg   <= 1'b1;
      susp_oe_n_reg  <= OE_DRIVE_N;
      clk_stop_n_reg <= PIN_ASSERT_N;
      s3_off_n_reg   <= PIN_ASSERT_N;
      s5_off_n_reg   <= PIN_ASSERT_N;
    end else if (force_s5) begin
      // No stop grant wait: both planes drop in the same cycle
      state_reg      <= ST_SLEEP;
      type_reg       <= S5_PLANE_OFF_N;
      link_req_reg   <= 1'b1;
      susp_oe_n_reg  <= OE_DRIVE_N;
      clk_stop_n_reg <= PIN_ASSERT_N;
      s3_off_n_reg   <= PIN_ASSERT_N;
      s5_off_n_reg   <= PIN_ASSERT_N;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (i_sleep_req && type_ok) begin
            type_reg  <= i_sleep_type;
            state_reg <= ST_WAIT_GNT;
          end else if (i_c3_req) begin
            state_reg <= ST_C3_GNT;
          end
        end
        ST_WAIT_GNT: begin
          if (lnk.stop_grant_message) begin
            susp_oe_n_reg <= OE_DRIVE_N;
            state_reg     <= ST_SUSP;
          end
        end
        ST_SUSP: begin
          if (lnk.stop_permit_in) begin
            link_req_reg <= 1'b1;
            state_reg    <= ST_LSTOP;
          end
        end
        ST_LSTOP: begin
          clk_stop_n_reg <= PIN_ASSERT_N;
          state_reg      <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (sleep_wake) begin
            s3_off_n_reg <= PIN_RELEASE_N;
            s5_off_n_reg <= PIN_RELEASE_N;
            if (type_reg < S3_PLANE_OFF_N) begin
              clk_stop_n_reg <= PIN_RELEASE_N;
              dly_reg        <= i_s1_exit_cycles;
              state_reg      <= ST_WAKE_DLY;
            end else begin
              state_reg <= ST_WAKE_PG;
            end
          end else begin
            // Clock stop went low a cycle earlier, planes follow here
            if (type_reg >= S3_PLANE_OFF_N) s3_off_n_reg <= PIN_ASSERT_N;
            if (type_reg >= SLP_S4) s5_off_n_reg <= PIN_ASSERT_N;
          end
        end
        ST_WAKE_PG: begin
          if (lnk.device_power_good) begin
            clk_stop_n_reg <= PIN_RELEASE_N;
            state_reg      <= ST_WAKE_LS;
          end
        end
        ST_WAKE_DLY: begin
          if (dly_reg == '0) state_reg <= ST_WAKE_LS;
          else dly_reg <= dly_reg - DW'(1);
        end
        ST_WAKE_LS: begin
          link_req_reg <= 1'b0;
          state_reg    <= ST_WAKE_SUS;
        end
        ST_WAKE_SUS: begin
          // Shared line: hold suspend until no one pulls link stop low
          if (lnk.cpu_link_stop_n) begin
            susp_oe_n_reg <= OE_FLOAT_N;
            state_reg     <= ST_RUN;
          end
        end
        ST_C3_GNT: begin
          if (lnk.stop_grant_message) state_reg <= ST_C3_LS;
        end
        ST_C3_LS: begin
          if (lnk.stop_permit_in) begin
            link_req_reg <= 1'b1;
            state_reg    <= ST_C3;
          end
        end
        ST_C3: begin
          if (~lnk.idle_break_n || wake_fall || pb_fall) begin
            dly_reg   <= i_c3_exit_cycles;
            state_reg <= ST_C3_EXIT;
          end
        end
        ST_C3_EXIT: begin
          if (dly_reg == '0) begin
            link_req_reg <= 1'b0;
            state_reg    <= ST_RUN;
          end else begin
            dly_reg <= dly_reg - DW'(1);
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pins
  // ----------------------------------------------------------------
  logic ls_oe_n_reg;
  logic permit_oe_n_reg;

  // Registered, so the pull releases one cycle after permit drops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ls_oe_n_reg     <= OE_FLOAT_N;
      permit_oe_n_reg <= OE_FLOAT_N;
    end else begin
      ls_oe_n_reg     <= ~(link_req_reg & lnk.stop_permit_in);
      permit_oe_n_reg <= ~(i_combined_link_mode & i_dma_busy);
    end
  end

  // ----------------------------------------------------------------
  // Wake arming and modes
  // ----------------------------------------------------------------
  // Arming is sticky; only a full reset (G3) clears it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pbo_lock_reg <= 1'b0;
      s5_armed_reg <= 1'b0;
      native_reg   <= 1'b0;
    end else begin
      if (pbo_fire) pbo_lock_reg <= 1'b1;
      else if (state_reg == ST_WAKE_SUS) pbo_lock_reg <= 1'b0;
      if (state_reg == ST_WAKE_SUS && type_reg == S5_PLANE_OFF_N) s5_armed_reg <= 1'b1;
      if (i_native_wake_wr) native_reg <= i_native_wake_data;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  logic run_press;
  assign run_press = pb_fall && (state_reg == ST_RUN);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_smi        <= 1'b0;
      o_sci        <= 1'b0;
      o_irq13      <= 1'b0;
      o_wake_event <= 1'b0;
    end else begin
      o_smi <= (run_press & ~i_pb_use_sci) | (alert_fall & ((i_alert_route == ALR_SMI_GPE) |
               (i_alert_route == ALR_SMI_DIRECT)));
      o_sci <= (run_press & i_pb_use_sci) | (alert_fall & (i_alert_route == ALR_SCI)) |
               (native_reg & wake_fall & (state_reg == ST_RUN));
      o_irq13      <= alert_fall & (i_alert_route == ALR_IRQ13);
      o_wake_event <= ((state_reg == ST_SLEEP) & sleep_wake & ~force_s5) |
                      ((state_reg != ST_SLEEP) & wake_fall);
    end
  end

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign lnk.cpu_clock_stop_n    = clk_stop_n_reg;
  assign lnk.s3_plane_off_n      = s3_off_n_reg;
  assign lnk.s5_plane_off_n      = s5_off_n_reg;
  assign lnk.suspend_status_o    = OD_LOW;
  assign lnk.suspend_status_oe_n = susp_oe_n_reg;
  assign lnk.dev_link_stop_o     = OD_LOW;
  assign lnk.dev_link_stop_oe_n  = ls_oe_n_reg;
  assign lnk.dev_permit_o        = OD_LOW;
  assign lnk.dev_permit_oe_n     = permit_oe_n_reg;
  assign o_native_wake           = native_reg;
  assign o_pbo_lock              = pbo_lock_reg;
  assign o_s5_wake_armed         = s5_armed_reg;
  assign o_state                 = state_reg;

endmodule

// *** src/sspsq_partner.sv ***
module sspsq_partner
  import sspsq_pkg::*;
#(
  parameter int PG_RISE = PG_RISE_CYCLES,
  parameter int NB_RISE = NB_PG_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Link toward the sequencer
  sspsq_if.far      lnk,
  // Stimulus from the platform side
  input  wire logic i_button_press,
  input  wire logic i_force_off,
  input  wire logic i_thermal_trip,
  input  wire logic i_thermal_alert,
  input  wire logic i_pcie_wake,
  input  wire logic i_idle_break,
  input  wire logic i_stop_grant,
  input  wire logic i_nb_permit,
  input  wire logic i_nb_hold_link_stop,
  // Observed line levels
  output logic      o_link_stop_seen,
  output logic      o_suspend_seen,
  output logic      o_device_pg
);

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic btn_n_reg;
  logic off_n_reg;
  logic trip_n_reg;
  logic alert_n_reg;
  logic wake_n_reg;
  logic idle_n_reg;
  logic grant_reg;
  logic nb_permit_oe_n_reg;
  logic nb_ls_oe_n_reg;

  // Northbridge pulls permit low to forbid a link stop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      btn_n_reg          <= PIN_RELEASE_N;
      off_n_reg          <= PIN_RELEASE_N;
      trip_n_reg         <= PIN_RELEASE_N;
      alert_n_reg        <= PIN_RELEASE_N;
      wake_n_reg         <= PIN_RELEASE_N;
      idle_n_reg         <= PIN_RELEASE_N;
      grant_reg          <= 1'b0;
      nb_permit_oe_n_reg <= OE_DRIVE_N;
      nb_ls_oe_n_reg     <= OE_FLOAT_N;
    end else begin
      btn_n_reg          <= ~i_button_press;
      off_n_reg          <= ~i_force_off;
      trip_n_reg         <= ~i_thermal_trip;
      alert_n_reg        <= ~i_thermal_alert;
      wake_n_reg         <= ~i_pcie_wake;
      idle_n_reg         <= ~i_idle_break;
      grant_reg          <= i_stop_grant;
      nb_permit_oe_n_reg <= i_nb_permit;
      nb_ls_oe_n_reg     <= ~i_nb_hold_link_stop;
    end
  end

  // ----------------------------------------------------------------
  // Board power-good circuit
  // ----------------------------------------------------------------
  logic [PG_CNT_W-1:0] nb_cnt_reg;
  logic [PG_CNT_W-1:0] pg_cnt_reg;
  logic                nb_pg_reg;
  logic                dev_pg_reg;
  logic                planes_on;
  assign planes_on = lnk.s3_plane_off_n & lnk.s5_plane_off_n;

  // Device good drops at once but rises only after a settle time
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nb_cnt_reg <= '0;
      pg_cnt_reg <= '0;
      nb_pg_reg  <= 1'b0;
      dev_pg_reg <= 1'b0;
    end else begin
      if (!planes_on) begin
        nb_cnt_reg <= '0;
        nb_pg_reg  <= 1'b0;
      end else if (nb_cnt_reg == PG_CNT_W'(NB_RISE)) begin
        nb_pg_reg <= 1'b1;
      end else begin
        nb_cnt_reg <= nb_cnt_reg + PG_CNT_W'(1);
      end
      if (!planes_on || !nb_pg_reg) begin
        pg_cnt_reg <= '0;
        dev_pg_reg <= 1'b0;
      end else if (pg_cnt_reg == PG_CNT_W'(PG_RISE)) begin
        dev_pg_reg <= 1'b1;
      end else begin
        pg_cnt_reg <= pg_cnt_reg + PG_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Observed levels and wiring
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_link_stop_seen <= 1'b0;
      o_suspend_seen   <= 1'b0;
    end else begin
      o_link_stop_seen <= ~lnk.cpu_link_stop_n;
      o_suspend_seen   <= ~lnk.suspend_status_n;
    end
  end

  assign lnk.power_button_n         = btn_n_reg;
  assign lnk.force_off_n            = off_n_reg;
  assign lnk.thermal_trip_n         = trip_n_reg;
  assign lnk.thermal_alert_n        = alert_n_reg;
  assign lnk.pcie_wake_n            = wake_n_reg;
  assign lnk.idle_break_n           = idle_n_reg;
  assign lnk.stop_grant_message     = grant_reg;
  assign lnk.nb_permit_o            = OD_LOW;
  assign lnk.nb_permit_oe_n         = nb_permit_oe_n_reg;
  assign lnk.nb_link_stop_o         = OD_LOW;
  assign lnk.nb_link_stop_oe_n      = nb_ls_oe_n_reg;
  assign lnk.northbridge_power_good = nb_pg_reg;
  assign lnk.device_power_good      = dev_pg_reg;
  assign o_device_pg                = dev_pg_reg;

endmodule

// *** sim/sspsq_asserts.sv ***
module sspsq_asserts (
  // Clock, reset and watched lines
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic stop_permit_in,
  input wire logic dev_link_stop_oe_n,
  input wire logic cpu_link_stop_n,
  input wire logic cpu_clock_stop_n,
  input wire logic s3_plane_off_n,
  input wire logic s5_plane_off_n,
  input wire logic force_off_n,
  input wire logic thermal_trip_n,
  input wire logic suspend_status_n,
  input wire logic device_power_good
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Sequencing checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Full shutdown: both planes off with the clock stopped
  sequence planes_off_s;
    !s3_plane_off_n && !s5_plane_off_n && !cpu_clock_stop_n;
  endsequence
  // Permit is registered, so allow one extra cycle of lag
  link_gate_a: assert property (!dev_link_stop_oe_n |-> $past(stop_permit_in) ||
    $past(stop_permit_in, 2)) else $error("link stop pulled without permit");
  s3_after_clk_a: assert property ($fell(s3_plane_off_n) |-> !cpu_clock_stop_n)
    else $error("s3 plane off before clock stop");
  s5_after_clk_a: assert property ($fell(s5_plane_off_n) |-> !cpu_clock_stop_n)
    else $error("s5 plane off before clock stop");
  s5_implies_s3_a: assert property (!s5_plane_off_n |-> !s3_plane_off_n)
    else $error("s5 plane off while s3 plane on");
  force_off_a: assert property ($fell(force_off_n) |=> planes_off_s)
    else $error("forced shutdown did not drop planes");
  trip_s5_a: assert property ($fell(thermal_trip_n) |=> planes_off_s)
    else $error("thermal trip did not enter s5");
  susp_release_a: assert property ($rose(suspend_status_n) |-> $past(cpu_link_stop_n))
    else $error("suspend freed before link stop");
  wake_pg_a: assert property ($rose(dev_link_stop_oe_n) |-> device_power_good)
    else $error("link stop freed without power good");
endmodule

// *** sim/sspsq_tb.sv ***
module sspsq_tb import sspsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, sreq, c3, clm, busy, sci, nwr, nwd, btn, foff, trip, alert, pwk, ibrk, gnt;
  logic permit, smi_o, sci_o, irq_o, wk_o, native, lock, armed, nbh, lsn, dpg;
  logic [2:0] styp, evt;
  logic [1:0] route;
  sspsq_state_e state;
  int mismatches, num_checks, wakes;
  logic [2:0] ev_exp [6] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h4, 3'h2};
  sspsq_if sspsq_if_i ();
  sspsq_device #(.PBO_HOLD_CYCLES(20)) sspsq_device_i (.i_clk(i_clk), .i_rst(i_rst),
    .lnk(sspsq_if_i), .i_sleep_req(sreq), .i_sleep_type(styp), .i_c3_req(c3),
    .i_combined_link_mode(clm), .i_dma_busy(busy), .i_s1_exit_cycles(16'h0004),
    .i_c3_exit_cycles(16'h0008), .i_pb_use_sci(sci), .i_alert_route(route),
    .i_native_wake_wr(nwr), .i_native_wake_data(nwd), .o_smi(smi_o), .o_sci(sci_o),
    .o_irq13(irq_o), .o_wake_event(wk_o), .o_native_wake(native), .o_pbo_lock(lock),
    .o_s5_wake_armed(armed), .o_state(state));
  sspsq_partner #(.PG_RISE(4), .NB_RISE(4)) sspsq_partner_i (.i_clk(i_clk), .i_rst(i_rst),
    .lnk(sspsq_if_i), .i_button_press(btn), .i_force_off(foff), .i_thermal_trip(trip),
    .i_thermal_alert(alert), .i_pcie_wake(pwk), .i_idle_break(ibrk), .i_stop_grant(gnt),
    .i_nb_permit(permit), .i_nb_hold_link_stop(nbh), .o_link_stop_seen(lsn),
    .o_suspend_seen(), .o_device_pg(dpg));
  sspsq_asserts sspsq_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
    .stop_permit_in(sspsq_if_i.stop_permit_in),
    .dev_link_stop_oe_n(sspsq_if_i.dev_link_stop_oe_n),
    .cpu_link_stop_n(sspsq_if_i.cpu_link_stop_n), .cpu_clock_stop_n(sspsq_if_i.cpu_clock_stop_n),
    .s3_plane_off_n(sspsq_if_i.s3_plane_off_n), .s5_plane_off_n(sspsq_if_i.s5_plane_off_n),
    .force_off_n(sspsq_if_i.force_off_n), .thermal_trip_n(sspsq_if_i.thermal_trip_n),
    .suspend_status_n(sspsq_if_i.suspend_status_n),
    .device_power_good(sspsq_if_i.device_power_good));
  // ------------------------------------------------------------
  // Clock and event capture; pulses last one cycle, so latch them
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    evt <= evt | {smi_o, sci_o, irq_o};
    wakes <= wakes + int'(wk_o);
  end
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    step(n);
    s = 1'b0;
    step(1);
  endtask
  // Bounded wait, then the state itself is compared
  task automatic wait_st(input sspsq_state_e s);
    for (int i = 0; i < 300 && state !== s; i++) step(1);
    chk("state", s, state);
  endtask
  task automatic do_sleep(input logic [2:0] t);
    styp = t;
    pulse(sreq, 1);
    step(3);
    pulse(gnt, 1);
    wait_st(ST_SLEEP);
    step(1); // Planes drop one cycle after sleep entry
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    {i_rst, sreq, c3, clm, busy, sci, nwr, nwd, btn, foff, trip, alert, pwk, ibrk, gnt} = '0;
    {styp, route, evt, permit, nbh, wakes} = '0;
    i_rst = 1'b1;
    step(3);
    i_rst = 1'b0;
    chk("native", 0, native);
    pulse(pwk, 2);
    step(10);
    chk("state", ST_SLEEP, state);
    pulse(btn, 3);
    wait_st(ST_RUN);
    chk("armed", 1, armed);
    chk("wakes", 1, wakes[3:0]);
    chk("planes", 3, {sspsq_if_i.s3_plane_off_n, sspsq_if_i.s5_plane_off_n});
    $display("test s5 wake done");
    for (int k = 0; k < 6; k++) begin
      evt = 3'h0;
      route = k[1:0];
      sci = k[0];
      if (k < 4) pulse(alert, 1);
      else pulse(btn, 3);
      step(4);
      chk("event", ev_exp[k], evt);
    end
    chk("state", ST_RUN, state);
    nwd = 1'b1;
    pulse(nwr, 1);
    chk("native", 1, native);
    $display("test events done");
    permit = 1'b1;
    do_sleep(S3_PLANE_OFF_N);
    chk("planes", 1, {sspsq_if_i.s3_plane_off_n, sspsq_if_i.s5_plane_off_n});
    chk("lnk_sus", 0, {sspsq_if_i.cpu_link_stop_n, sspsq_if_i.suspend_status_n});
    pulse(pwk, 2);
    wait_st(ST_RUN);
    chk("lnk_sus", 3, {sspsq_if_i.cpu_link_stop_n, sspsq_if_i.suspend_status_n});
    chk("pg", 1, dpg);
    $display("test s3 done");
    permit = 1'b0;
    pulse(c3, 1);
    step(3);
    pulse(gnt, 1);
    step(10);
    chk("link", 1, sspsq_if_i.cpu_link_stop_n);
    {clm, busy, permit} = 3'h7;
    step(3);
    chk("permit", 0, sspsq_if_i.stop_permit_in);
    busy = 1'b0;
    wait_st(ST_C3);
    pulse(ibrk, 1);
    wait_st(ST_C3_EXIT);
    step(7);
    chk("link", 0, sspsq_if_i.cpu_link_stop_n);
    wait_st(ST_RUN);
    clm = 1'b0;
    $display("test c3 done");
    nbh = 1'b1;
    step(3);
    chk("nb_link", 1, lsn);
    nbh = 1'b0;
    step(3);
    chk("nb_link", 0, lsn);
    do_sleep(SLP_S1);
    btn = 1'b1;
    step(25);
    btn = 1'b0;
    step(5);
    chk("lock", 1, lock);
    pulse(pwk, 2);
    step(10);
    chk("state", ST_SLEEP, state);
    pulse(btn, 3);
    wait_st(ST_RUN);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) pulse(foff, 1);
      else pulse(trip, 1);
      chk("planes", 0, {sspsq_if_i.s3_plane_off_n, sspsq_if_i.s5_plane_off_n});
      pulse(btn, 3);
      wait_st(ST_RUN);
    end
    $display("test shutdown done");
    end_of_test();
  end
endmodule
